// *** logic/atm_pkg.sv ***
// Purpose: Shared constants for the transceiver test-mode logic.
// Assumes: One 250 MHz fabric clock; all test pins are sampled on it.
// Notes:   Chain lengths and divider ratios are used by the top; the bench also reads the chain lengths.
package atm_pkg;
    // Number of internal scan chains.
    localparam int NUM_CHAINS = 8;
    // Lengths of scan chains one to eight, in bits.
    localparam int CHAIN_LEN [NUM_CHAINS] = '{54, 54, 54, 54, 53, 53, 51, 31};
    // Index of the one chain that shifts on the rising external clock edge.
    localparam int RISE_CHAIN = 7;
    // Pin bit positions inside the functional output vector.
    localparam int POS_CHANNEL_MODE = 4;
    // System clock to sample rate ratios and the internal timing rate.
    localparam int RATIO_LOW  = 256;
    localparam int RATIO_HIGH = 384;
    localparam int TIMING_RATIO = 128;
    // System clock edges per internal timing tick for each ratio.
    localparam int DIV_LOW  = RATIO_LOW / TIMING_RATIO;
    localparam int DIV_HIGH = RATIO_HIGH / TIMING_RATIO;
    localparam int DIV_W = 2;
    // Value of the divider counter after reset.
    localparam logic [DIV_W-1:0] DIV_RESET = 2'h0;
    // Synchroniser depth for every pin input.
    localparam int SYNC_STAGES = 2;
endpackage

// *** logic/atm_scan_if.sv ***
// Purpose: Carries the shift strobe and serial data between the top and one scan chain.
// Assumes: Single clock domain; shiftEn is a one-cycle enable.
// Notes:   One instance per chain.
`timescale 1ns/1ps
interface atm_scan_if;
    logic shiftEn;  // One-cycle shift enable.
    logic serIn;    // Serial data into the chain.
    logic serOut;   // Last flip-flop of the chain.
    modport chain (input shiftEn, input serIn, output serOut);
    modport ctrl  (output shiftEn, output serIn, input serOut);
endinterface

// *** logic/atm_scan_chain.sv ***
// Purpose: One scan chain built as a shift register of flip-flops.
// Assumes: Shift enable is already qualified by scan mode and the right clock edge.
// Notes:   The serial output is the last stage, so it is registered.
`timescale 1ns/1ps
module atm_scan_chain #(
    parameter int LEN = 54
) (
    input  wire logic  clk,      // Fabric clock.
    input  wire logic  sys_rst,  // Synchronous reset, active high.
    atm_scan_if.chain  scan      // Shift strobe and serial data.
);
    logic [LEN-1:0] chain_r;
    logic [LEN-1:0] chain_nxt;

    // Computes the next chain contents: shift one place toward the output on each strobe.
    always_comb begin
        chain_nxt = chain_r;
        if (scan.shiftEn) begin
            chain_nxt = {chain_r[LEN-2:0], scan.serIn};
        end
    end

    // Registers the chain.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            chain_r <= '0;
        end else begin
            chain_r <= chain_nxt;
        end
    end

    assign scan.serOut = chain_r[LEN-1];
endmodule

// *** logic/atm_test_top.sv ***
// Purpose: Test-mode and scan-test control of a biphase-mark audio transceiver.
// Assumes: All pins arrive asynchronously and pass two flip-flops first; the
//          external and recovered clocks are sampled as levels on clk.
// Notes:   Scan shifting is done on edge-enable pulses derived from the sampled
//          external clock, so the fabric keeps a single clock.
// How it works
// - Test select A low keeps normal running, high takes the system clock from the external clock input.
// - With test select A high, scan select high puts all flip-flops into scan shift, low keeps ordinary test.
// - In scan mode the loop-filter hold resistor switch is held open whatever the inputs say.
// - Test select C high makes the channel-mode pin carry the internal system clock outside scan mode; in scan mode it carries chain five.
// - There are eight chains of 54, 54, 54, 54, 53, 53, 51 and 31 bits.
// - Each chain enters on a functional input pin and leaves on a functional output pin.
// - Chains one to seven shift on the falling external clock edge, chain eight on the rising edge.
// - Outside scan mode the hold resistor connects when the receive input has no signal or the oscillator is off.
// - Internal timing ticks once per 128th of a sample period while the system clock runs at 256 or 384 fs.
`timescale 1ns/1ps
module atm_test_top (
    input  wire logic       clk,               // Fabric clock, 250 MHz.
    input  wire logic       sys_rst,           // Synchronous reset, active high.
    input  wire logic       testSelectA,       // Test select A pin.
    input  wire logic       scanSelect,        // Scan select pin.
    input  wire logic       testSelectC,       // Test select C pin.
    input  wire logic       extClockIn,        // External system clock input pin.
    input  wire logic       recoveredClockIn,  // Recovered clock from the loop.
    input  wire logic       slicerIn,          // Slicer output of the sensitive biphase input.
    input  wire logic       funcBiphaseIn,     // Normal biphase output from the encoder.
    input  wire logic       rxMode,            // High in receive mode.
    input  wire logic       signalPresent,     // Selected biphase input carries a signal.
    input  wire logic       oscillatorOff,     // Oscillator is switched off.
    input  wire logic       pllLock,           // Loop reports lock.
    input  wire logic       clockRatioSelect,  // High for 256 fs, low for 384 fs; chain eight input.
    input  wire logic [6:0] scanInPins,        // Functional input pins feeding chains one to seven.
    input  wire logic [7:0] funcOut,           // Normal values of the eight chain output pins.
    output logic      [7:0] pinOut,            // Chain output pins.
    output logic            biphaseOutput,     // Biphase output pin.
    output logic            sysClkFromExt,     // System clock source select, high for external.
    output logic            scanModeActive,    // All flip-flops in scan shift.
    output logic            holdResistorOn,    // Hold resistor switch closed.
    output logic            ramTestEnable,     // User-data RAM test enabled.
    output logic            timingTick,        // One pulse per internal timing period.
    output logic            recoveredClockValid // Recovered clock frequency may be trusted.
);
    localparam int NSYNC = 14;

    // Two-stage synchronisers for every pin input.
    logic [NSYNC-1:0] syncA_r;
    logic [NSYNC-1:0] syncB_r;
    logic [NSYNC-1:0] pinRaw;
    assign pinRaw = {scanInPins, clockRatioSelect, slicerIn, recoveredClockIn,
                     extClockIn, scanSelect, testSelectC, testSelectA};

    // Samples the pins twice; only the second stage is read below.
    // The stages keep sampling through reset, because the test-select latch
    // reads them while reset is held; clearing them would hide the pins.
    always_ff @(posedge clk) begin
        syncA_r <= pinRaw;
        syncB_r <= syncA_r;
    end

    logic       tstA;
    logic       tstScan;
    logic       tstC;
    logic       extClk;
    logic       recClk;
    logic       slicer;
    logic       ratioSel;
    logic [6:0] chainIn;
    assign tstA     = syncB_r[0];
    assign tstC     = syncB_r[1];
    assign tstScan  = syncB_r[2];
    assign extClk   = syncB_r[3];
    assign recClk   = syncB_r[4];
    assign slicer   = syncB_r[5];
    assign ratioSel = syncB_r[6];
    assign chainIn  = syncB_r[13:7];

    // Test selects are caught while reset is held and then kept static.
    logic modeA_r;
    logic modeScan_r;
    logic modeC_r;
    logic modeA_nxt;
    logic modeScan_nxt;
    logic modeC_nxt;

    // Computes the latched test mode; it may change only during reset.
    always_comb begin
        modeA_nxt    = modeA_r;
        modeScan_nxt = modeScan_r;
        modeC_nxt    = modeC_r;
        if (sys_rst) begin
            modeA_nxt    = tstA;
            modeScan_nxt = tstScan;
            modeC_nxt    = tstC;
        end
    end

    // Registers the test mode.
    always_ff @(posedge clk) begin
        modeA_r    <= modeA_nxt;
        modeScan_r <= modeScan_nxt;
        modeC_r    <= modeC_nxt;
    end

    // Scan mode needs both test select A and scan select.
    logic scanMode;
    assign scanMode = modeA_r & modeScan_r;

    // The system clock follows the external input in test mode, else the recovered clock.
    logic sysClkLevel;
    assign sysClkLevel = modeA_r ? extClk : recClk;

    // Edge detection on the sampled clocks.
    logic extClkPrev_r;
    logic sysClkPrev_r;
    logic extFall;
    logic extRise;
    logic sysRise;
    assign extFall = extClkPrev_r & ~extClk;
    assign extRise = ~extClkPrev_r & extClk;
    assign sysRise = ~sysClkPrev_r & sysClkLevel;

    // Timing divider: two system clock edges per tick at 256 fs, three at 384 fs.
    logic [atm_pkg::DIV_W-1:0] divCnt_r;
    logic [atm_pkg::DIV_W-1:0] divCnt_nxt;
    logic [atm_pkg::DIV_W-1:0] divLast;
    logic                      tick_nxt;
    assign divLast = ratioSel ? atm_pkg::DIV_W'(atm_pkg::DIV_LOW - 1)
                              : atm_pkg::DIV_W'(atm_pkg::DIV_HIGH - 1);

    // Computes the divider count and the tick pulse.
    always_comb begin
        divCnt_nxt = divCnt_r;
        tick_nxt   = 1'b0;
        if (sysRise) begin
            if (divCnt_r >= divLast) begin
                divCnt_nxt = atm_pkg::DIV_RESET;
                tick_nxt   = 1'b1;
            end else begin
                divCnt_nxt = divCnt_r + 1'b1;
            end
        end
    end

    // Scan chains, joined by interfaces.
    atm_scan_if chainIf [atm_pkg::NUM_CHAINS] ();
    logic [7:0] chainOut;

    // Chains one to seven shift on falling, chain eight on rising external edges.
    // Chain inputs come from functional pins.
    // Chain lengths follow the package table.
    for (genvar g = 0; g < atm_pkg::NUM_CHAINS; g++) begin : gChain
        if (g == atm_pkg::RISE_CHAIN) begin : gRise
            assign chainIf[g].shiftEn = scanMode & extRise;
            assign chainIf[g].serIn   = ratioSel;
        end else begin : gFall
            assign chainIf[g].shiftEn = scanMode & extFall;
            assign chainIf[g].serIn   = chainIn[g];
        end
        assign chainOut[g] = chainIf[g].serOut;
        atm_scan_chain #(
            .LEN (atm_pkg::CHAIN_LEN[g])
        ) uChain (
            .clk     (clk),
            .sys_rst (sys_rst),
            .scan    (chainIf[g])
        );
    end

    // Output values computed before registering.
    logic [7:0] pinOut_nxt;
    logic       biphase_nxt;
    logic       hold_nxt;
    logic       valid_nxt;

    // Computes the pin outputs, the resistor switch and the clock validity.
    always_comb begin
        pinOut_nxt = funcOut;
        if (modeC_r) begin
            pinOut_nxt[atm_pkg::POS_CHANNEL_MODE] = sysClkLevel;
        end
        if (scanMode) begin
            pinOut_nxt = chainOut;
        end
        biphase_nxt = modeC_r ? slicer : funcBiphaseIn;
        // Hold resistor connects on lost signal or stopped oscillator, never in scan.
        hold_nxt = ~scanMode & ((rxMode & ~signalPresent) | oscillatorOff);
        // In receive mode the recovered clock is trusted only in lock.
        valid_nxt = ~rxMode | pllLock;
    end

    // Registers the edge detectors, the divider and all outputs.
    // The edge detectors follow the sampled clocks even in reset, so a pin
    // that is already high at release does not count as a fresh edge.
    always_ff @(posedge clk) begin
        extClkPrev_r <= extClk;
        sysClkPrev_r <= sysClkLevel;
        if (sys_rst) begin
            divCnt_r            <= atm_pkg::DIV_RESET;
            timingTick          <= 1'b0;
            pinOut              <= 8'h00;
            biphaseOutput       <= 1'b0;
            sysClkFromExt       <= 1'b0;
            scanModeActive      <= 1'b0;
            holdResistorOn      <= 1'b0;
            ramTestEnable       <= 1'b0;
            recoveredClockValid <= 1'b0;
        end else begin
            divCnt_r            <= divCnt_nxt;
            timingTick          <= tick_nxt;
            pinOut              <= pinOut_nxt;
            biphaseOutput       <= biphase_nxt;
            sysClkFromExt       <= modeA_r;
            scanModeActive      <= scanMode;
            holdResistorOn      <= hold_nxt;
            ramTestEnable       <= modeC_r;
            recoveredClockValid <= valid_nxt;
        end
    end
endmodule

// *** test/atm_test_equipment.sv ***
// Purpose: Test equipment model that drives the external clock pin.
// Assumes: Driven on falling fabric edges; each phase lasts two cycles or more.
// Notes:   The clock stands still between requests.
`timescale 1ns/1ps
module atm_test_equipment (
    input  wire logic clk,    // Fabric clock.
    output logic      extClk  // External clock pin.
);
    initial extClk = 1'b0;
    // One rising then one falling edge, each phase held for the given cycles.
    task automatic pulse(input int hi, input int lo);
        @(negedge clk);
        extClk = 1'b1;
        repeat (hi) @(negedge clk);
        extClk = 1'b0;
        repeat (lo - 1) @(negedge clk);
    endtask
    // Parks the clock at a static level.
    task automatic level(input logic v);
        @(negedge clk);
        extClk = v;
    endtask
endmodule

// *** test/atm_test_assertions.sv ***
// Purpose: Port assertions for the test-mode top.
// Assumes: One clock with a synchronous reset.
// Notes:   Pin inputs show at the outputs three edges later.
`timescale 1ns/1ps
module atm_test_assertions (
    input wire logic       clk,                 // Clock.
    input wire logic       sys_rst,             // Reset.
    input wire logic       extClockIn,          // Ext clock.
    input wire logic       funcBiphaseIn,       // Encoder.
    input wire logic       rxMode,              // Receive.
    input wire logic       signalPresent,       // Signal.
    input wire logic       oscillatorOff,       // Osc off.
    input wire logic       pllLock,             // Lock.
    input wire logic [7:0] pinOut,              // Pins.
    input wire logic       biphaseOutput,       // Biphase.
    input wire logic       sysClkFromExt,       // Source.
    input wire logic       scanModeActive,      // Scan.
    input wire logic       holdResistorOn,      // Hold.
    input wire logic       ramTestEnable,       // RAM test.
    input wire logic       timingTick,          // Tick.
    input wire logic       recoveredClockValid  // Valid.
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [1:0] upCnt;
    // Counts edges since reset until the pin pipelines are full.
    always_ff @(posedge clk)
        upCnt <= sys_rst ? 2'h0 : upCnt + {1'b0, upCnt != 2'h3};
    // Mode, hold switch, pin and clock relations.
    a_scan_needs_a: assert property (scanModeActive |-> sysClkFromExt)
        else $error("scan without test mode");
    a_scan_hold_open: assert property (scanModeActive |-> !holdResistorOn)
        else $error("hold closed in scan");
    a_hold_switch: assert property (upCnt == 2'h3 |-> holdResistorOn == (!scanModeActive &&
        (($past(rxMode) && !$past(signalPresent)) || $past(oscillatorOff)))) else $error("hold wrong");
    a_select_stable: assert property (upCnt == 2'h3 |-> $stable(sysClkFromExt) && $stable(ramTestEnable))
        else $error("mode moved after reset");
    a_channel_mode_output_clock: assert property (upCnt == 2'h3 && ramTestEnable && sysClkFromExt && !scanModeActive
        |-> pinOut[4] == $past(extClockIn, 3)) else $error("mode pin not clock");
    a_biphase_normal: assert property (upCnt == 2'h3 && !ramTestEnable
        |-> biphaseOutput == $past(funcBiphaseIn)) else $error("biphase wrong");
    a_clock_valid: assert property (upCnt == 2'h3
        |-> recoveredClockValid == (!$past(rxMode) || $past(pllLock))) else $error("valid wrong");
    a_tick_pulse: assert property (timingTick |=> !timingTick)
        else $error("tick too long");
endmodule
bind atm_test_top atm_test_assertions chk (.clk, .sys_rst, .extClockIn, .funcBiphaseIn, .rxMode,
    .signalPresent, .oscillatorOff, .pllLock, .pinOut, .biphaseOutput, .sysClkFromExt, .scanModeActive,
    .holdResistorOn, .ramTestEnable, .timingTick, .recoveredClockValid);

// *** test/atm_test_top_test.sv ***
// Purpose: Self-checking bench for the test-mode top.
// Assumes: Test selects change only while reset is held.
// Notes:   Walks normal, test and scan modes in turn.
`timescale 1ns/1ps
module atm_test_top_test;
    logic       clk, sys_rst, testSelectA, scanSelect, testSelectC, extClockIn, recoveredClockIn;
    logic       slicerIn, funcBiphaseIn, rxMode, signalPresent, oscillatorOff, pllLock;
    logic       clockRatioSelect, biphaseOutput, sysClkFromExt, scanModeActive, holdResistorOn;
    logic       ramTestEnable, timingTick, recoveredClockValid;
    logic [6:0] scanInPins;
    logic [7:0] funcOut, pinOut, expVec;
    int         failures = 0, checksDone = 0, cycles = 0, ticks = 0;
    atm_test_top dut (.clk, .sys_rst, .testSelectA, .scanSelect, .testSelectC, .extClockIn,
        .recoveredClockIn, .slicerIn, .funcBiphaseIn, .rxMode, .signalPresent, .oscillatorOff,
        .pllLock, .clockRatioSelect, .scanInPins, .funcOut, .pinOut, .biphaseOutput, .sysClkFromExt,
        .scanModeActive, .holdResistorOn, .ramTestEnable, .timingTick, .recoveredClockValid);
    atm_test_equipment eq (.clk, .extClk(extClockIn));
    // Clock generator.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Counts ticks and cuts a hang short.
    always @(posedge clk) begin
        cycles++;
        if (timingTick === 1'b1) ticks++;
        if (cycles == 20000) begin
            failures++;
            summarize();
        end
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checksDone++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Sets the test selects only while reset is held.
    task automatic resetWith(input logic a, input logic b, input logic c);
        @(negedge clk);
        {sys_rst, testSelectA, scanSelect, testSelectC} = {1'b1, a, b, c};
        repeat (4) @(negedge clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    // Counts ticks over 24 external clock periods at one ratio.
    task automatic tickRun(input logic ratio, input logic [7:0] exp);
        clockRatioSelect = ratio;
        resetWith(1'b1, 1'b0, 1'b1);
        ticks = 0;
        repeat (24) eq.pulse(4, 4);
        repeat (8) @(negedge clk);
        check("ticks", ticks[7:0], exp);
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", checksDone, failures);
        if (failures == 0 && checksDone > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Main test sequence.
    initial begin
        {sys_rst, testSelectA, scanSelect, testSelectC, recoveredClockIn, slicerIn} = 6'h20;
        {funcBiphaseIn, rxMode, signalPresent, oscillatorOff, pllLock, clockRatioSelect} = 6'h00;
        {scanInPins, funcOut} = 15'h0000;
        resetWith(1'b0, 1'b0, 1'b0);
        check("modes", {5'h00, sysClkFromExt, scanModeActive, ramTestEnable}, 8'h00);
        {funcOut, funcBiphaseIn} = {8'h5A, 1'b1};
        repeat (2) @(negedge clk);
        check("pins", pinOut, 8'h5A);
        check("biphase", {7'h00, biphaseOutput}, 8'h01);
        for (int i = 0; i < 8; i++) begin
            {rxMode, signalPresent, oscillatorOff} = i[2:0];
            pllLock = i[1];
            repeat (2) @(negedge clk);
            check("hold", {7'h00, holdResistorOn}, {7'h00, (i[2] & ~i[1]) | i[0]});
            check("valid", {7'h00, recoveredClockValid}, {7'h00, ~i[2] | i[1]});
        end
        $display("test normal done");
        resetWith(1'b1, 1'b0, 1'b1);
        check("modes", {5'h00, sysClkFromExt, scanModeActive, ramTestEnable}, 8'h05);
        {funcOut, slicerIn, funcBiphaseIn} = {8'hFF, 1'b1, 1'b0};
        repeat (4) @(negedge clk);
        check("channel_mode_output low", pinOut, 8'hEF);
        check("slicer", {7'h00, biphaseOutput}, 8'h01);
        {funcOut, slicerIn} = {8'h00, 1'b0};
        eq.level(1'b1);
        repeat (4) @(negedge clk);
        check("channel_mode_output high", pinOut, 8'h10);
        eq.level(1'b0);
        tickRun(1'b1, 8'h0C);
        tickRun(1'b0, 8'h08);
        $display("test clock done");
        {rxMode, signalPresent, oscillatorOff, funcOut} = {3'h5, 8'hFF};
        resetWith(1'b1, 1'b1, 1'b0);
        check("modes", {5'h00, sysClkFromExt, scanModeActive, ramTestEnable}, 8'h06);
        check("hold scan", {7'h00, holdResistorOn}, 8'h00);
        for (int n = 1; n <= 56; n++) begin
            scanInPins = (n == 1) ? 7'h7F : 7'h00;
            clockRatioSelect = (n == 1);
            eq.pulse(4, 4);
            repeat (4) @(negedge clk);
            for (int g = 0; g < atm_pkg::NUM_CHAINS; g++) expVec[g] = (n == atm_pkg::CHAIN_LEN[g]);
            check("scan out", pinOut, expVec);
        end
        $display("test scan done");
        summarize();
    end
endmodule
